// file: plc_pkg.sv
// Shared constants and types for the loop control and lock model.
package plc_pkg;

  localparam int unsigned CNT_W        = 8;
  localparam int unsigned TAP_W        = 3;
  localparam int unsigned PER_W        = 16;
  localparam int unsigned DIV_W        = 8;
  localparam int unsigned NOUT_DEF     = 3;
  // Fine phase steps per VCO period; one step is one clk_i cycle.
  localparam int unsigned TAPS         = 8;
  localparam int unsigned LOCK_MIN     = 2;
  localparam int unsigned LOCK_MAX     = 10;
  localparam int unsigned LOCK_CYC_DEF = 4;
  // VCO period window, in clk_i cycles.
  localparam int unsigned VCO_PER_MIN  = 2;
  localparam int unsigned VCO_PER_MAX  = 64;
  localparam logic [PER_W-1:0] PER_RST = 16'h0000;
  localparam logic [CNT_W+TAP_W:0] CNT_RST = 12'h000;

  typedef enum logic [1:0] {
    PLC_OFF,
    PLC_ACQ,
    PLC_LOCK
  } plc_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] high;
    logic [CNT_W-1:0] low;
    logic [CNT_W-1:0] init;
    logic [TAP_W-1:0] tap;
  } plc_out_cfg_t;

  typedef struct packed {
    logic [DIV_W-1:0] mult;
    logic [DIV_W-1:0] div;
  } plc_ratio_t;

endpackage

// file: plc_pll_ctrl.sv
// Digital control, lock and post-scale logic of a phase-locked loop.
//
// Notes on behaviour
// - Enable low drops lock and holds every output clock low.
// - Reset input high drops lock and forces every output clock low.
// - Detector enable low holds lock at its current value; output clocks keep toggling.
// - Lock asserts two to ten reference cycles after acquisition begins.
// - On input frequency change, check fin*M/N against VCO range; lose lock outside.
// - Fine phase is a tap index zero to seven, eighth-period steps.
// - Each counter waits an initial number of VCO cycles before counting.
// - Counter splits into high and low counts setting the duty cycle.
module plc_pll_ctrl #(
  parameter int unsigned NOUT     = plc_pkg::NOUT_DEF,
  parameter int unsigned LOCK_CYC = plc_pkg::LOCK_CYC_DEF
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  nrst_i,
  input  wire logic                                  ref_clk_i,
  input  wire logic                                  pll_en_i,
  input  wire logic                                  areset_i,
  input  wire logic                                  pfd_en_i,
  input  wire plc_pkg::plc_ratio_t                   ratio_i,
  input  wire plc_pkg::plc_out_cfg_t [NOUT-1:0]      out_cfg_i,
  output logic [NOUT-1:0]                            clk_o,
  output logic                                       locked_o
);

  localparam int unsigned CW = plc_pkg::CNT_W + plc_pkg::TAP_W + 1;
  localparam int unsigned PW = plc_pkg::PER_W;
  localparam int unsigned MW = PW + plc_pkg::DIV_W;

  // Scale a VCO-cycle count into clk_i cycles; a zero count acts as one.
  function automatic logic [CW-1:0] vco_cyc(input logic [plc_pkg::CNT_W-1:0] n);
    logic [CW-1:0] v;
    v = (n == '0) ? CW'(1) : CW'(n);
    return CW'(v * CW'(plc_pkg::TAPS));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Control pins are asynchronous to clk_i.
  logic [3:0] meta_r;
  logic [2:0] sync_r;
  logic       ref_d_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r  <= 4'h0;
      sync_r  <= 3'h0;
      ref_d_r <= 1'b0;
    end else begin
      meta_r  <= {ref_clk_i, pll_en_i, areset_i, pfd_en_i};
      sync_r  <= meta_r[2:0];
      ref_d_r <= meta_r[3];
    end
  end

  logic ref_s_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ref_s_r <= 1'b0;
    end else begin
      ref_s_r <= ref_d_r;
    end
  end

  logic en_s, rst_s, pfd_s, run, ref_edge;
  assign en_s     = sync_r[2];
  assign rst_s    = sync_r[1];
  assign pfd_s    = sync_r[0];
  assign run      = en_s && !rst_s;
  assign ref_edge = ref_d_r && !ref_s_r;

  //////////////////////////////////////////////////////////////////////////
  // Reference period measurement and VCO range check.
  logic [PW-1:0] per_cnt_r, per_r;
  logic          per_vld_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_cnt_r <= plc_pkg::PER_RST;
      per_r     <= plc_pkg::PER_RST;
      per_vld_r <= 1'b0;
    end else if (!run) begin
      per_cnt_r <= plc_pkg::PER_RST;
      per_r     <= plc_pkg::PER_RST;
      per_vld_r <= 1'b0;
    end else if (ref_edge) begin
      per_cnt_r <= PW'(1);
      per_r     <= per_cnt_r;
      per_vld_r <= 1'b1;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + PW'(1);
    end
  end

  logic [MW-1:0] per_n, lim_lo, lim_hi;
  logic          in_range, freq_chg;
  assign per_n    = MW'(per_cnt_r) * MW'(ratio_i.div);
  assign lim_lo   = MW'(ratio_i.mult) * MW'(plc_pkg::VCO_PER_MIN);
  assign lim_hi   = MW'(ratio_i.mult) * MW'(plc_pkg::VCO_PER_MAX);
  assign in_range = per_vld_r && (ratio_i.mult != '0) && (per_n >= lim_lo) && (per_n <= lim_hi);
  assign freq_chg = per_vld_r && (per_cnt_r != per_r);

  //////////////////////////////////////////////////////////////////////////
  // Lock acquisition.
  plc_pkg::plc_state_t state_r, state_nxt;
  logic [3:0]          lock_cnt_r;
  logic                locked_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      plc_pkg::PLC_OFF:  state_nxt = plc_pkg::PLC_ACQ;
      plc_pkg::PLC_ACQ:  if (pfd_s && ref_edge && in_range && !freq_chg &&
                             lock_cnt_r == 4'(LOCK_CYC - 1)) begin
                           state_nxt = plc_pkg::PLC_ACQ == state_r ? plc_pkg::PLC_LOCK
                                                                   : state_r;
                         end
      plc_pkg::PLC_LOCK: if (pfd_s && ref_edge && freq_chg && !in_range) begin
                           state_nxt = plc_pkg::PLC_ACQ;
                         end
    endcase
    if (!run) begin
      state_nxt = plc_pkg::PLC_OFF;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r  <= plc_pkg::PLC_OFF;
      locked_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      locked_r <= (state_nxt == plc_pkg::PLC_LOCK);
    end
  end

  // Lock counting stalls while the phase detector is off.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_cnt_r <= 4'h0;
    end else if (!run || state_r != plc_pkg::PLC_ACQ) begin
      lock_cnt_r <= 4'h0;
    end else if (pfd_s && ref_edge) begin
      lock_cnt_r <= (in_range && !freq_chg) ? lock_cnt_r + 4'h1 : 4'h0;
    end
  end

  assign locked_o = locked_r;

  //////////////////////////////////////////////////////////////////////////
  // Post-scale counters, one per output clock.
  logic [NOUT-1:0] clk_r, started_r;
  logic [CW-1:0]   cnt_r [NOUT];
  logic [CW-1:0]   wait_tgt [NOUT];

  for (genvar i = 0; i < NOUT; i++) begin : g_out
    assign wait_tgt[i] = CW'(CW'(out_cfg_i[i].init) * CW'(plc_pkg::TAPS)) +
                         CW'(out_cfg_i[i].tap);

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        clk_r[i]     <= 1'b0;
        started_r[i] <= 1'b0;
        cnt_r[i]     <= plc_pkg::CNT_RST;
      end else if (!run) begin
        clk_r[i]     <= 1'b0;
        started_r[i] <= 1'b0;
        cnt_r[i]     <= plc_pkg::CNT_RST;
      end else if (!started_r[i]) begin
        if (cnt_r[i] == wait_tgt[i]) begin
          started_r[i] <= 1'b1;
          clk_r[i]     <= 1'b1;
          cnt_r[i]     <= vco_cyc(out_cfg_i[i].high) - CW'(1);
        end else begin
          cnt_r[i] <= cnt_r[i] + CW'(1);
        end
      end else if (cnt_r[i] == '0) begin
        clk_r[i] <= !clk_r[i];
        cnt_r[i] <= (clk_r[i] ? vco_cyc(out_cfg_i[i].low)
                              : vco_cyc(out_cfg_i[i].high)) - CW'(1);
      end else begin
        cnt_r[i] <= cnt_r[i] - CW'(1);
      end
    end

    AST_PHASE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      $rose(started_r[i]) |-> $past(cnt_r[i]) == $past(wait_tgt[i]))
      else $error("Output started before its initial wait elapsed.");
    AST_TAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (run && !started_r[i]) |-> wait_tgt[i][plc_pkg::TAP_W-1:0] == out_cfg_i[i].tap)
      else $error("Fine phase offset differs from tap index.");
    AST_DUTY: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (run && started_r[i] && !clk_r[i] && cnt_r[i] == '0) ##1 run |->
      clk_r[i] && cnt_r[i] == vco_cyc($past(out_cfg_i[i].high)) - CW'(1))
      else $error("High phase not loaded from high count.");
    AST_PFD_RUN: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (run && !pfd_s && started_r[i] && cnt_r[i] == '0) |=> !run || $changed(clk_r[i]))
      else $error("Output stopped toggling while detector off.");
  end

  assign clk_o = clk_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks on lock and gating.
  AST_EN_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !en_s |=> !locked_o && clk_o == '0)
    else $error("Lock or clock active while disabled.");
  AST_RST_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rst_s |=> !locked_o && clk_o == '0)
    else $error("Lock or clock active during reset input.");
  AST_PFD_HOLD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (run && !pfd_s) ##1 run |-> $stable(locked_r))
    else $error("Lock changed while detector off.");
  AST_LOCK_CNT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(locked_r) |-> $past(lock_cnt_r) == 4'(LOCK_CYC - 1) &&
    LOCK_CYC >= plc_pkg::LOCK_MIN && LOCK_CYC <= plc_pkg::LOCK_MAX)
    else $error("Lock asserted after wrong reference cycle count.");
  AST_RANGE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (run && pfd_s && ref_edge && freq_chg && !in_range) |=> !locked_r)
    else $error("Lock kept with VCO out of range.");
  AST_RESTART: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state_r == plc_pkg::PLC_OFF) |=> lock_cnt_r == 4'h0 && !locked_r)
    else $error("Lock count not restarted.");

  COV_LOCK: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(locked_r));
  COV_LOSS: cover property (@(posedge clk_i) disable iff (!nrst_i)
    locked_r && run ##1 !locked_r);
  COV_PFD: cover property (@(posedge clk_i) disable iff (!nrst_i)
    locked_r && !pfd_s ##1 locked_r);

endmodule

// file: plc_ref_src.sv
// Reference clock source that feeds the loop's input pin.
module plc_ref_src (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] half_i,
  output logic             ref_clk_o,
  output logic [15:0]      edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  initial begin
    ref_clk_o = 1'b0;
    edges_o = 16'h0000;
    cnt_r = 16'h0000;
  end
  // The source stands low while stopped, so no stray edge reaches the lock counter.
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt_r <= 16'h0000;
      ref_clk_o <= 1'b0;
    end else if (cnt_r + 16'h0001 >= half_i) begin
      cnt_r <= 16'h0000;
      ref_clk_o <= ~ref_clk_o;
      edges_o <= edges_o + {15'h0000, ~ref_clk_o};
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule

// file: plc_pll_ctrl_tb.sv
// Self-checking bench for the loop control and lock logic.
module plc_pll_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                            clk_i;
  logic                            nrst_i;
  logic                            pll_en_i;
  logic                            areset_i;
  logic                            pfd_en_i;
  logic                            ref_run;
  logic                            ref_clk;
  logic [15:0]                     half;
  logic [15:0]                     edges;
  plc_pkg::plc_ratio_t             ratio;
  plc_pkg::plc_out_cfg_t [2:0]     cfg;
  logic [2:0]                      clk_o;
  logic                            locked_o;
  int                              bad_count;
  int                              check_count;
  plc_ref_src i_plc_ref_src (.clk_i(clk_i), .run_i(ref_run), .half_i(half),
    .ref_clk_o(ref_clk), .edges_o(edges));
  plc_pll_ctrl #(.NOUT(3), .LOCK_CYC(4)) i_plc_pll_ctrl (.clk_i(clk_i), .nrst_i(nrst_i),
    .ref_clk_i(ref_clk), .pll_en_i(pll_en_i), .areset_i(areset_i), .pfd_en_i(pfd_en_i),
    .ratio_i(ratio), .out_cfg_i(cfg), .clk_o(clk_o), .locked_o(locked_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // A lock level that never arrives is a hang, so the run ends here as failed.
  task automatic wait_lock(input logic lvl);
    int k;
    for (k = 0; k < 600 && locked_o !== lvl; k++) tick();
    if (locked_o !== lvl) begin
      bad_count++;
      finish_test();
    end
  endtask
  // A fresh count needs LOCK_CYC+2 edges; a resumed one may need fewer.
  task automatic relock(input int e0, input int lo);
    wait_lock(1'b1);
    check("lock_edges", (edges - e0 >= lo) && (edges - e0 <= plc_pkg::LOCK_MAX), 1);
  endtask
  task automatic duty(input int i, input int hi, input int lo);
    int h;
    int l;
    h = 0;
    l = 0;
    while (clk_o[i] !== 1'b0 && l < 99) begin tick(); l++; end
    while (clk_o[i] !== 1'b1 && h < 99) begin tick(); h++; end
    h = 0;
    l = 0;
    while (clk_o[i] === 1'b1 && h < 99) begin tick(); h++; end
    while (clk_o[i] === 1'b0 && l < 99) begin tick(); l++; end
    check("high_time", h, hi);
    check("low_time", l, lo);
    if (h >= 99 || l >= 99) begin
      bad_count++;
      finish_test();
    end
  endtask
  // A disabled or reset loop shows no clock edge and no lock for a while.
  task automatic hold_off();
    int k;
    bit ok;
    ok = 1;
    repeat (4) tick();
    for (k = 0; k < 40; k++) begin
      tick();
      if ({locked_o, clk_o} !== 4'h0) ok = 0;
    end
    check("outputs_off", ok, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios: phase offsets, detector off, range, ratio, enable and reset
  task automatic sc_start();
    int t[3];
    int k;
    int e0;
    t = '{-1, -1, -1};
    @(posedge clk_i);
    pll_en_i <= 1'b1;
    ref_run <= 1'b1;
    e0 = edges;
    for (k = 0; k < 40; k++) begin
      tick();
      for (int i = 0; i < 3; i++) if (t[i] < 0 && clk_o[i] === 1'b1) t[i] = k;
    end
    check("rise_gap_0_2", t[0] - t[2], 3);
    check("rise_gap_1_0", t[1] - t[0], 11);
    relock(e0, 5);
    duty(0, 8, 8);
    duty(1, 24, 8);
    duty(2, 16, 16);
  endtask
  task automatic sc_pfd();
    @(posedge clk_i);
    pfd_en_i <= 1'b0;
    repeat (100) tick();
    duty(1, 24, 8);
    check("lock_pfd_off", locked_o, 1'b1);
    @(posedge clk_i);
    pfd_en_i <= 1'b1;
  endtask
  task automatic sc_range();
    @(posedge clk_i);
    half <= 16'h0028;
    wait_lock(1'b0);
    check("lock_out_of_range", locked_o, 1'b0);
    @(posedge clk_i);
    half <= 16'h0008;
    relock(edges, 5);
  endtask
  task automatic sc_ratio();
    @(posedge clk_i);
    ratio <= '{mult: 8'h01, div: 8'h05};
    half <= 16'h0009;
    wait_lock(1'b0);
    check("lock_div_range", locked_o, 1'b0);
    @(posedge clk_i);
    ratio <= '{mult: 8'h02, div: 8'h05};
    relock(edges, 2);
    @(posedge clk_i);
    ratio <= '{mult: 8'h01, div: 8'h01};
    half <= 16'h0008;
    repeat (100) tick();
    check("lock_in_range_change", locked_o, 1'b1);
  endtask
  task automatic sc_enable();
    @(posedge clk_i);
    pll_en_i <= 1'b0;
    hold_off();
    @(posedge clk_i);
    pll_en_i <= 1'b1;
    relock(edges, 5);
  endtask
  task automatic sc_areset();
    @(posedge clk_i);
    areset_i <= 1'b1;
    hold_off();
    @(posedge clk_i);
    areset_i <= 1'b0;
    relock(edges, 5);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    check_count = 0;
    nrst_i = 1'b0;
    pll_en_i = 1'b0;
    areset_i = 1'b0;
    pfd_en_i = 1'b1;
    ref_run = 1'b0;
    half = 16'h0008;
    ratio = '{mult: 8'h01, div: 8'h01};
    cfg[0] = '{high: 8'h01, low: 8'h01, init: 8'h01, tap: 3'h0};
    cfg[1] = '{high: 8'h03, low: 8'h01, init: 8'h02, tap: 3'h3};
    cfg[2] = '{high: 8'h02, low: 8'h02, init: 8'h00, tap: 3'h5};
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    sc_start();
    sc_pfd();
    sc_range();
    sc_ratio();
    sc_enable();
    sc_areset();
    finish_test();
  end
endmodule
